// [rfcb_pkg.sv]
// constants of the right-channel effects coefficient bank: offsets, resets, widths
// assumes the bank sits on register page one of the serial control bus
// Operation
// - each coefficient is its high byte register followed by its low byte register.
// - each coefficient word is a signed two's-complement value, every code valid.
// - reset loads numerator tap four with high byte 0x96 and low byte 0x66.
// - reset loads numerator tap five with high byte 0x67 and low byte 0x5d.
// - reset loads denominator tap one with high byte 0x7d and low byte 0x83.
// - reset loads denominator tap two with high byte 0x84 and low byte 0xee.
// - reset loads denominator tap four with high byte 0x7d and low byte 0x83.
package rfcb_pkg;
  localparam int BYTE_W = 8;
  localparam int COEF_W = 16;
  localparam int NUM_REGS = 10;
  // bus addressing
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h18;
  localparam logic [7:0] PAGE_SEL_OFFSET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  localparam logic [7:0] COEF_PAGE = 8'h01;
  // register offsets on the coefficient page
  localparam logic [7:0] RIGHT_FX_NUM_FOUR_HIGH = 8'h23;
  localparam logic [7:0] RIGHT_FX_NUM_FOUR_LOW = 8'h24;
  localparam logic [7:0] RIGHT_FX_NUM_FIVE_HIGH = 8'h25;
  localparam logic [7:0] RIGHT_FX_NUM_FIVE_LOW = 8'h26;
  localparam logic [7:0] RIGHT_FX_DEN_ONE_HIGH = 8'h27;
  localparam logic [7:0] RIGHT_FX_DEN_ONE_LOW = 8'h28;
  localparam logic [7:0] RIGHT_FX_DEN_TWO_HIGH = 8'h29;
  localparam logic [7:0] RIGHT_FX_DEN_TWO_LOW = 8'h2a;
  localparam logic [7:0] RIGHT_FX_DEN_FOUR_HIGH = 8'h2b;
  localparam logic [7:0] RIGHT_FX_DEN_FOUR_LOW = 8'h2c;
  localparam logic [7:0] BANK_BASE = RIGHT_FX_NUM_FOUR_HIGH;
  // reset values, indexed by offset minus the bank base
  localparam logic [7:0] RST_NUM_FOUR_HIGH = 8'h96;
  localparam logic [7:0] RST_NUM_FOUR_LOW = 8'h66;
  localparam logic [7:0] RST_NUM_FIVE_HIGH = 8'h67;
  localparam logic [7:0] RST_NUM_FIVE_LOW = 8'h5d;
  localparam logic [7:0] RST_DEN_ONE_HIGH = 8'h7d;
  localparam logic [7:0] RST_DEN_ONE_LOW = 8'h83;
  localparam logic [7:0] RST_DEN_TWO_HIGH = 8'h84;
  localparam logic [7:0] RST_DEN_TWO_LOW = 8'hee;
  localparam logic [7:0] RST_DEN_FOUR_HIGH = 8'h7d;
  localparam logic [7:0] RST_DEN_FOUR_LOW = 8'h83;
  localparam logic [NUM_REGS*8-1:0] RESET_VALUES = {
    RST_DEN_FOUR_LOW, RST_DEN_FOUR_HIGH, RST_DEN_TWO_LOW, RST_DEN_TWO_HIGH,
    RST_DEN_ONE_LOW, RST_DEN_ONE_HIGH, RST_NUM_FIVE_LOW, RST_NUM_FIVE_HIGH,
    RST_NUM_FOUR_LOW, RST_NUM_FOUR_HIGH};
  // serial bit count of one byte
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  // slave sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACK_ADDR = 7'h04,
    ST_RX = 7'h08,
    ST_ACK_RX = 7'h10,
    ST_TX = 7'h20,
    ST_ACK_TX = 7'h40
  } rfcb_state_t;
endpackage

// [rfcb_bank_if.sv]
// byte access path between the serial slave and the coefficient store
// assumes one clock; writes are single-cycle strobes
`timescale 1ns/1ps
interface rfcb_bank_if;
  logic sel;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr_en;
  logic [7:0] rdata;
  modport master (output sel, output addr, output wdata, output wr_en, input rdata);
  modport slave (input sel, input addr, input wdata, input wr_en, output rdata);
endinterface

// [rfcb_sync.sv]
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to clk; only the second stage is read
`timescale 1ns/1ps
module rfcb_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // idle level at reset so no false start is seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= IDLE_LEVEL;
      sync_out <= IDLE_LEVEL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [rfcb_bank.sv]
// coefficient byte store with registered read data and a packed byte vector output
// assumes the master gates writes to the coefficient page through sel
`timescale 1ns/1ps
module rfcb_bank (
  input wire logic clk,
  input wire logic reset_n,
  rfcb_bank_if.slave bus,
  output logic [rfcb_pkg::NUM_REGS*8-1:0] bytes
);
  logic [7:0] index;
  logic hit;

  // offset decode relative to the bank base
  assign index = bus.addr - rfcb_pkg::BANK_BASE;
  assign hit = bus.sel && (index < 8'(rfcb_pkg::NUM_REGS));

  // one byte register per entry, each with its own reset
  for (genvar i = 0; i < rfcb_pkg::NUM_REGS; i++) begin : g_byte
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        bytes[i*8 +: 8] <= rfcb_pkg::RESET_VALUES[i*8 +: 8];
      end else if (bus.wr_en && hit && index == 8'(i)) begin
        bytes[i*8 +: 8] <= bus.wdata;
      end
    end
  end

  // read data from a register; off-bank addresses read zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus.rdata <= 8'h00;
    end else begin
      bus.rdata <= hit ? bytes[index[3:0]*8 +: 8] : 8'h00;
    end
  end

  chk_write_lands: assert property (@(posedge clk) disable iff (!reset_n)
    (bus.wr_en && hit) |=> bytes[$past(index[3:0])*8 +: 8] == $past(bus.wdata))
    else $error("written byte not stored");
  chk_read_returns: assert property (@(posedge clk) disable iff (!reset_n)
    (hit && !bus.wr_en) |=> bus.rdata == bytes[$past(index[3:0])*8 +: 8])
    else $error("read data differs from stored byte");
endmodule

// [rfcb_top.sv]
// right-channel effects coefficient bank behind the serial control bus slave
// assumes an open-drain two-wire bus, slow beside clk; pins pass two flops
`timescale 1ns/1ps
module rfcb_top #(
  parameter logic [6:0] DEV_ADDR = rfcb_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [7:0] page_sel,
  output logic signed [15:0] numerator_tap_four,
  output logic signed [15:0] numerator_tap_five,
  output logic signed [15:0] denominator_tap_one,
  output logic signed [15:0] denominator_tap_two,
  output logic signed [15:0] denominator_tap_four
);
  rfcb_bank_if bus ();

  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  rfcb_pkg::rfcb_state_t state_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic rw_q;
  logic first_q;
  logic nack_q;
  logic [rfcb_pkg::NUM_REGS*8-1:0] bytes;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic byte_done;
  logic addr_match;
  logic commit;
  logic [7:0] read_byte;

  rfcb_sync #(
    .WIDTH(2),
    .IDLE_LEVEL(2'h3)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  rfcb_bank u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .bus(bus),
    .bytes(bytes)
  );

  // previous synchronised levels for edge and condition detect
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // bus events; data changing while the clock is high frames a transfer
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_cond = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_cond = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign byte_done = scl_fall && (cnt_q == rfcb_pkg::BITS_PER_BYTE);
  assign addr_match = shift_q[7:1] == DEV_ADDR;
  assign commit = (state_q == rfcb_pkg::ST_RX) && byte_done;

  // byte access path: the first received byte is the pointer, later ones data
  assign bus.sel = page_sel == rfcb_pkg::COEF_PAGE;
  assign bus.addr = ptr_q;
  assign bus.wdata = shift_q;
  assign bus.wr_en = commit && !first_q;
  // page select answers on every page; bank read data lag ptr by one clk
  assign read_byte = (ptr_q == rfcb_pkg::PAGE_SEL_OFFSET) ? page_sel : bus.rdata;

  // data pin value held low; the enable alone sets the line level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0; // open drain: only the enable ever moves
    end
  end
  // coefficient words: high byte above low byte, taken as signed
  assign numerator_tap_four = $signed({bytes[7:0], bytes[15:8]});
  assign numerator_tap_five = $signed({bytes[23:16], bytes[31:24]});
  assign denominator_tap_one = $signed({bytes[39:32], bytes[47:40]});
  assign denominator_tap_two = $signed({bytes[55:48], bytes[63:56]});
  assign denominator_tap_four = $signed({bytes[71:64], bytes[79:72]});

  // page select register; a write to offset zero moves every later access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_sel <= rfcb_pkg::PAGE_RESET;
    end else if (bus.wr_en && ptr_q == rfcb_pkg::PAGE_SEL_OFFSET) begin
      page_sel <= shift_q;
    end
  end

  // receive shifter samples on rising clock while a byte comes in
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_q <= 8'h00;
    end else if (scl_rise && (state_q == rfcb_pkg::ST_ADDR || state_q == rfcb_pkg::ST_RX)) begin
      shift_q <= {shift_q[6:0], sda_s};
    end
  end

  // pointer: loaded by the first written byte, then steps after each byte
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_q <= 8'h00;
    end else if (commit) begin
      ptr_q <= first_q ? shift_q : ptr_q + 8'h01;
    end else if (scl_fall && state_q == rfcb_pkg::ST_TX && cnt_q == 4'h7) begin
      ptr_q <= ptr_q + 8'h01;
    end
  end

  // sequencer; stop and repeated start override whatever byte is in flight
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= rfcb_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_cond) begin
      state_q <= rfcb_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_cond) begin
      state_q <= rfcb_pkg::ST_ADDR;
      cnt_q <= 4'h0;
      sda_oe <= 1'b0;
    end else begin
      unique case (state_q)
        rfcb_pkg::ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        rfcb_pkg::ST_ADDR: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            // foreign address: stay off the bus until the next start
            state_q <= addr_match ? rfcb_pkg::ST_ACK_ADDR : rfcb_pkg::ST_IDLE;
            sda_oe <= addr_match;
            rw_q <= shift_q[0];
          end
        end
        rfcb_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            cnt_q <= 4'h0;
            first_q <= 1'b1;
            if (rw_q) begin
              state_q <= rfcb_pkg::ST_TX;
              tx_q <= {read_byte[6:0], 1'b0};
              sda_oe <= !read_byte[7];
            end else begin
              state_q <= rfcb_pkg::ST_RX;
              sda_oe <= 1'b0;
            end
          end
        end
        rfcb_pkg::ST_RX: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + 4'h1;
          end else if (byte_done) begin
            state_q <= rfcb_pkg::ST_ACK_RX;
            first_q <= 1'b0;
            sda_oe <= 1'b1; // every byte is acked, even one that no register stores
          end
        end
        rfcb_pkg::ST_ACK_RX: begin
          if (scl_fall) begin
            state_q <= rfcb_pkg::ST_RX;
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
          end
        end
        rfcb_pkg::ST_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              state_q <= rfcb_pkg::ST_ACK_TX;
              sda_oe <= 1'b0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              sda_oe <= !tx_q[7];
              tx_q <= {tx_q[6:0], 1'b0};
            end
          end
        end
        rfcb_pkg::ST_ACK_TX: begin
          if (scl_rise) begin
            nack_q <= sda_s;
          end else if (scl_fall) begin
            // master nack ends the read; ack fetches the next byte
            cnt_q <= 4'h0;
            if (nack_q) begin
              state_q <= rfcb_pkg::ST_IDLE;
              sda_oe <= 1'b0;
            end else begin
              state_q <= rfcb_pkg::ST_TX;
              tx_q <= {read_byte[6:0], 1'b0};
              sda_oe <= !read_byte[7];
            end
          end
        end
        default: begin
          state_q <= rfcb_pkg::ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // helper: high only in the first cycle after reset release
  logic fresh_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  sequence s_fresh;
    fresh_q;
  endsequence

  chk_num_four_reset: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh |-> numerator_tap_four == 16'h9666)
    else $error("numerator tap four reset value wrong");
  chk_num_five_reset: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh |-> numerator_tap_five == 16'h675d)
    else $error("numerator tap five reset value wrong");
  chk_den_one_reset: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh |-> denominator_tap_one == 16'h7d83)
    else $error("denominator tap one reset value wrong");
  chk_den_two_reset: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh |-> denominator_tap_two == 16'h84ee)
    else $error("denominator tap two reset value wrong");
  chk_den_four_reset: assert property (@(posedge clk) disable iff (!reset_n)
    s_fresh |-> denominator_tap_four == 16'h7d83)
    else $error("denominator tap four reset value wrong");
  chk_high_byte_order: assert property (@(posedge clk) disable iff (!reset_n)
    (bus.wr_en && bus.sel && ptr_q == rfcb_pkg::RIGHT_FX_NUM_FOUR_HIGH)
      |=> numerator_tap_four[15:8] == $past(shift_q))
    else $error("high byte did not land in upper half");
  chk_sign_follows: assert property (@(posedge clk) disable iff (!reset_n)
    (denominator_tap_two < 0) == bytes[55])
    else $error("coefficient sign not taken from high byte");
  chk_write_ack: assert property (@(posedge clk) disable iff (!reset_n)
    (commit && !start_cond && !stop_cond) |=> sda_oe)
    else $error("received byte not acknowledged");

  // framing shapes shared by the access checks below
  sequence s_byte_taken;
    commit && !start_cond && !stop_cond;
  endsequence

  sequence s_read_launch;
    (state_q == rfcb_pkg::ST_ACK_ADDR) && rw_q && scl_fall;
  endsequence

  // scl cannot fall twice in a row, so the ack stands at least two clocks
  chk_ack_holds: assert property (@(posedge clk) disable iff (!reset_n)
    s_byte_taken |=> sda_oe [*2])
    else $error("acknowledge released too early");
  chk_read_first_bit: assert property (@(posedge clk) disable iff (!reset_n)
    s_read_launch |=> sda_oe == !$past(read_byte[7]))
    else $error("first read bit not driven from register");
  chk_low_byte_order: assert property (@(posedge clk) disable iff (!reset_n)
    (bus.wr_en && bus.sel && ptr_q == rfcb_pkg::RIGHT_FX_NUM_FOUR_LOW)
      |=> numerator_tap_four[7:0] == $past(shift_q))
    else $error("low byte did not land in lower half");
  chk_den_four_order: assert property (@(posedge clk) disable iff (!reset_n)
    (bus.wr_en && bus.sel && ptr_q == rfcb_pkg::RIGHT_FX_DEN_FOUR_HIGH)
      |=> denominator_tap_four[15:8] == $past(shift_q))
    else $error("denominator high byte did not land in upper half");
  // writes while another page is selected must leave the bank untouched
  chk_page_gates_bank: assert property (@(posedge clk) disable iff (!reset_n)
    (bus.wr_en && !bus.sel) |=> $stable(bytes))
    else $error("bank written while another page selected");
  chk_stop_releases: assert property (@(posedge clk) disable iff (!reset_n)
    stop_cond |=> !sda_oe)
    else $error("data line still driven after stop");
  chk_state_onehot: assert property (@(posedge clk) disable iff (!reset_n)
    $onehot(state_q))
    else $error("sequencer state not one-hot");
endmodule

// [rfcb_bench.sv]
// self-checking bench for the right-channel coefficient bank
// assumes the two-wire slave of rfcb_top; the bench plays bus master and pull-up
`timescale 1ns/1ps
module rfcb_bench;
  localparam logic [6:0] ADDR = rfcb_pkg::DEV_ADDR_DEFAULT;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  logic sda_out;
  logic sda_oe;
  logic [7:0] page_sel;
  logic signed [15:0] coef [5];
  logic [7:0] buf_b [10];
  logic [7:0] got [10];
  logic [7:0] rst_b [10];
  int fails = 0;
  int compares = 0;
  // open-drain wire: pulled high unless a party pulls it low
  wire logic sda_line = sda_m & (sda_oe ? sda_out : 1'b1);

  rfcb_top #(.DEV_ADDR(ADDR)) DUT (.clk(clk), .reset_n(reset_n), .scl_in(scl_m),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .page_sel(page_sel),
    .numerator_tap_four(coef[0]), .numerator_tap_five(coef[1]),
    .denominator_tap_one(coef[2]), .denominator_tap_two(coef[3]),
    .denominator_tap_four(coef[4]));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk16(input string name, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic finish_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // bus phases of six clocks keep clear of the five-clock minimum
  task automatic half();
    repeat (6) @(posedge clk);
  endtask

  task automatic bitx(input logic v, output logic r);
    sda_m <= v;
    half();
    scl_m <= 1'b1;
    half();
    r = sda_line;
    scl_m <= 1'b0;
    half();
  endtask

  // sda rises before scl so a repeated start never looks like a stop
  task automatic start();
    sda_m <= 1'b1;
    half();
    scl_m <= 1'b1;
    half();
    sda_m <= 1'b0;
    half();
    scl_m <= 1'b0;
    half();
  endtask

  task automatic stop();
    sda_m <= 1'b0;
    half();
    scl_m <= 1'b1;
    half();
    sda_m <= 1'b1;
    half();
  endtask

  task automatic byte_tx(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(b[i], r);
    end
    bitx(1'b1, r);
    chk8("ack", 8'h00, {7'h00, r});
  endtask

  task automatic byte_rx(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, b[i]);
    end
    bitx(last, r);
  endtask

  task automatic wr_regs(input logic [7:0] ptr, input int n);
    start();
    byte_tx({ADDR, 1'b0});
    byte_tx(ptr);
    for (int i = 0; i < n; i++) begin
      byte_tx(buf_b[i]);
    end
    stop();
  endtask

  task automatic rd_regs(input logic [7:0] ptr, input int n);
    start();
    byte_tx({ADDR, 1'b0});
    byte_tx(ptr);
    start();
    byte_tx({ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      byte_rx(i == n - 1, got[i]);
    end
    stop();
  endtask

  // five coefficient words against a byte table in offset order
  task automatic chk_words(input logic [7:0] e [10]);
    for (int k = 0; k < 5; k++) begin
      chk16("coefficient", {e[2*k], e[2*k+1]}, coef[k]);
    end
  endtask

  task automatic chk_bytes(input logic [7:0] e [10]);
    for (int i = 0; i < 10; i++) begin
      chk8("byte readback", e[i], got[i]);
    end
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic set_page();
    buf_b[0] = rfcb_pkg::COEF_PAGE;
    wr_regs(8'h00, 1);
    chk8("page_sel", 8'h01, page_sel);
  endtask

  initial begin
    rst_b = '{8'h96, 8'h66, 8'h67, 8'h5d, 8'h7d, 8'h83, 8'h84, 8'hee, 8'h7d, 8'h83};
    do_reset();
    chk8("page_sel", 8'h00, page_sel);
    chk_words(rst_b);
    set_page();
    rd_regs(8'h23, 10);
    chk_bytes(rst_b);
    $display("test reset_values done");
    // extremes of the signed range, minus one, one and a plain value
    buf_b = '{8'h80, 8'h00, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h01, 8'h12, 8'h34};
    wr_regs(8'h23, 10);
    chk_words(buf_b);
    chk8("min negative", 8'h01, {7'h00, coef[0] < 0});
    chk8("max positive", 8'h01, {7'h00, coef[1] > 0});
    chk8("minus one", 8'h01, {7'h00, coef[2] < 0});
    rd_regs(8'h23, 10);
    chk_bytes(buf_b);
    $display("test full_write done");
    // high byte alone: word is half new until the low byte follows
    buf_b[0] = 8'hc3;
    wr_regs(8'h2b, 1);
    chk16("half updated", 16'hc334, coef[4]);
    rd_regs(8'h2b, 2);
    chk8("high byte", 8'hc3, got[0]);
    chk8("low byte", 8'h34, got[1]);
    $display("test half_update done");
    // second reset in mid-run restores every byte
    do_reset();
    chk8("page_sel", 8'h00, page_sel);
    chk_words(rst_b);
    set_page();
    rd_regs(8'h23, 10);
    chk_bytes(rst_b);
    $display("test second_reset done");
    finish_test();
  end

  // the whole sequence needs roughly 11000 clocks
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("CHECK FAILED watchdog expected done seen hang");
    finish_test();
  end
endmodule
